// ==== sim/periodic_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_two_consts.svh"

module periodic_timer_tb;
   localparam logic [7:0] MSK = `OFF_TIMER_MASK_TWO;
   localparam logic [7:0] FLG = `OFF_TIMER_FLAG_TWO;
   localparam logic [7:0] ACC = `OFF_ACC_CONTROL;
   localparam logic [7:0] CNT = `OFF_FREE_COUNTER;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, irq_q;
   logic normal_mode, acc_wrap, acc_edge;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, a, b;
   wire logic hready;
   int failures, check_count, cyc, rise, r1;

   assign hready = hreadyout;

   periodic_timer periodic_timer_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .normal_mode(normal_mode),
      .accumulator_wrap(acc_wrap), .accumulator_edge(acc_edge), .irq(irq));

   always #2.5 hclk = ~hclk;

   // Cycles since release and the cycle of the latest irq rise
   always @(posedge hclk) begin
      cyc <= hresetn ? cyc + 1 : 0;
      if (irq === 1'b1 && !irq_q) rise <= cyc;
      irq_q <= (irq === 1'b1);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge hclk);
      haddr <= {24'h0, ad};
      hwrite <= 1'b1;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, ad};
      hwrite <= 1'b0;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : rd

   // Counter samples taken 160 cycles apart
   task automatic check_rate(input logic [31:0] exp);
      rd(CNT, a);
      repeat (157) @(posedge hclk);
      rd(CNT, b);
      chk(b - a, exp);
   endtask : check_rate

   task automatic wait_irq(input int n);
      int i;
      i = 0;
      @(posedge hclk);
      while (irq !== 1'b1 && i < n) begin
         @(posedge hclk);
         i++;
      end
      // Let the rise recorder settle before anyone reads it
      @(negedge hclk);
      chk({31'h0, irq}, 32'h1);
   endtask : wait_irq

   // Mid-run reset, then a first ratio write after the window has closed
   task automatic window_check;
      hresetn <= 1'b0;
      normal_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (70) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(MSK, 8'h43);
      rd(MSK, a);
      chk(a, 32'h40);
   endtask : window_check

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      #450_000;
      failures++;
      tally_and_finish();
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b1;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      normal_mode = 1'b1;
      acc_wrap = 1'b0;
      acc_edge = 1'b0;
      failures = 0;
      check_count = 0;
      cyc = 0;
      rise = 0;
      irq_q = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(FLG, a); chk(a, 32'h0);
      rd(ACC, a); chk(a, 32'h0);
      wr(MSK, 8'h4F); rd(MSK, a); chk(a, 32'h43);
      wr(MSK, 8'h4C); rd(MSK, a); chk(a, 32'h43);
      check_rate(32'hA);
      normal_mode <= 1'b0;
      wr(MSK, 8'h41); rd(MSK, a); chk(a, 32'h41);
      check_rate(32'h28);
      wr(MSK, 8'h40); rd(MSK, a); chk(a, 32'h40);
      check_rate(32'hA0);
      // First timeout one whole period after release
      wait_irq(9000);
      chk({31'h0, rise >= 8190 && rise <= 8196}, 32'h1);
      repeat (1000) @(posedge hclk);
      wr(FLG, 8'h00); rd(FLG, a); chk(a, 32'h40);
      wr(FLG, 8'h40); rd(FLG, a); chk(a, 32'h0);
      chk({31'h0, irq}, 32'h0);
      r1 = rise;
      wait_irq(9000);
      chk(rise - r1, 32'h2000);
      // Slower rate measured over one full interval
      wr(ACC, 8'h01); rd(ACC, a); chk(a, 32'h1);
      wr(FLG, 8'h40);
      wait_irq(17000);
      r1 = rise;
      wr(FLG, 8'h40);
      wait_irq(17000);
      chk(rise - r1, 32'h4000);
      wr(FLG, 8'h40);
      wr(MSK, 8'h30);
      @(posedge hclk);
      acc_wrap <= 1'b1;
      acc_edge <= 1'b1;
      @(posedge hclk);
      acc_wrap <= 1'b0;
      acc_edge <= 1'b0;
      rd(FLG, a); chk(a & 32'h30, 32'h30);
      chk({31'h0, irq}, 32'h1);
      wr(FLG, 8'h10); rd(FLG, a); chk(a & 32'h30, 32'h20);
      wr(FLG, 8'h20); rd(FLG, a); chk(a & 32'h30, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Wrap of the counter with only its enable set
      wr(MSK, 8'h80);
      wait_irq(70000);
      rd(FLG, a); chk(a & 32'h80, 32'h80);
      rd(CNT, a); chk({31'h0, a < 32'h100}, 32'h1);
      wr(FLG, 8'h80); rd(FLG, a); chk(a & 32'hB0, 32'h0);
      chk({31'h0, irq}, 32'h0);
      window_check();
      tally_and_finish();
   end
endmodule : periodic_timer_tb

`default_nettype wire

// ==== verilog/periodic_timer.sv ====
// Functional notes
// - Free-running counter advances every 1, 4, 8 or 16 clocks per ratio 00..11.
// - In normal mode ratio takes one write, only within 64 cycles of reset.
// - Each mask enable pairs with the flag at the same bit; both set requests interrupt.
// - Writing one clears a flag; writing zero leaves it alone.
// - Counter stepping from all ones to zero sets the wrap flag.
// - Wrap enable high requests interrupt while wrap flag set.
// - Periodic period is clock over 2^13, times 1, 2, 4 or 8 by rate.
// - Periodic timebase ignores the counter divider ratio.
// - Periodic divider chain runs continuously; only reset stops it.
// - Each period counts from the previous timeout, not from flag clear.
// - Each timeout sets periodic flag; with enable, interrupt is requested.
// - First periodic flag comes one whole period after reset.
// - Writing flag register with bit 6 set clears periodic flag.
// - Periodic enable high requests interrupt while periodic flag set.
// - Mask register bits 3 and 2 read zero.
// - Flag register bits 3 to 0 read zero.
// - Accumulator wrap event sets flag bit 5.
// - Accumulator selected edge sets flag bit 4.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer_two_consts.svh"

module periodic_timer
   import timer_two_pkg::*;
#(
   parameter logic [6:0] WINDOW_CYCLES = `WRITE_WINDOW_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Operating mode and accumulator events
   input wire logic normal_mode,
   input wire logic accumulator_wrap,
   input wire logic accumulator_edge,
   // Interrupt request
   output logic irq
);

   localparam state_t RESET_STATE = '{
      en: `RST_ENABLES,
      ratio: `RST_RATIO,
      ratio_locked: 1'b0,
      win_cnt: 7'h00,
      flags: `RST_FLAGS,
      acc_ctl: `RST_ACC_CONTROL,
      prescale: 4'h0,
      counter: `RST_COUNTER,
      chain: `RST_CHAIN,
      wr_pend: 1'b0,
      wr_addr: 8'h00,
      hrdata: 32'h0000_0000,
      hreadyout: 1'b1,
      hresp: 1'b0,
      irq: 1'b0
   };

   state_t s;
   state_t next_s;
   logic addr_take;
   logic tick;
   logic timeout;
   logic [15:0] tap_mask;
   logic [3:0] set_ev;
   logic [3:0] clr_ev;
   logic ratio_open;

   function automatic reg_sel_t decode(input logic [7:0] addr);
      case (addr)
         `OFF_TIMER_MASK_TWO: decode = SEL_MASK;
         `OFF_TIMER_FLAG_TWO: decode = SEL_FLAG;
         `OFF_ACC_CONTROL: decode = SEL_ACC;
         `OFF_FREE_COUNTER: decode = SEL_COUNT;
         default: decode = SEL_NONE;
      endcase
   endfunction : decode

   function automatic logic [3:0] prescale_last(input logic [1:0] ratio);
      case (ratio)
         2'h0: prescale_last = `PRESCALE_LAST_DIV1;
         2'h1: prescale_last = `PRESCALE_LAST_DIV4;
         2'h2: prescale_last = `PRESCALE_LAST_DIV8;
         default: prescale_last = `PRESCALE_LAST_DIV16;
      endcase
   endfunction : prescale_last

   // Address phase is taken on any selected NONSEQ or SEQ transfer with hready high
   assign addr_take = hsel && htrans[1] && hready;

   // Counter advances once per prescaler cycle
   assign tick = (s.prescale >= prescale_last(s.ratio));

   // Timeout when every chain bit below the selected tap is one
   assign tap_mask = `PERIODIC_BASE_MASK | (`PERIODIC_BASE_MASK << s.acc_ctl[1:0]);
   assign timeout = ((s.chain & tap_mask) == tap_mask);

   // Ratio field stays open only early after reset, in normal mode
   assign ratio_open = !normal_mode || (!s.ratio_locked && (s.win_cnt < WINDOW_CYCLES));

   always_comb begin
      next_s = s;
      set_ev = 4'h0;
      clr_ev = 4'h0;
      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;

      // Bus address phase
      next_s.wr_pend = addr_take && hwrite && (hsize == 3'h2);
      next_s.wr_addr = haddr[7:0];
      next_s.hrdata = 32'h0000_0000;
      if (addr_take && !hwrite) begin
         case (decode(haddr[7:0]))
            SEL_MASK: next_s.hrdata[7:0] = {s.en, 2'b00, s.ratio};
            SEL_FLAG: next_s.hrdata[7:0] = {s.flags, 4'h0};
            SEL_ACC: next_s.hrdata[7:0] = s.acc_ctl;
            SEL_COUNT: next_s.hrdata[15:0] = s.counter;
            default: next_s.hrdata = 32'h0000_0000;
         endcase
      end

      // Window counter saturates at the end of the write window
      if (s.win_cnt < WINDOW_CYCLES) begin
         next_s.win_cnt = s.win_cnt + 7'h01;
      end

      // Bus data phase
      if (s.wr_pend) begin
         case (decode(s.wr_addr))
            SEL_MASK: begin
               next_s.en = hwdata[7:4];
               if (ratio_open) begin
                  next_s.ratio = hwdata[1:0];
                  next_s.ratio_locked = 1'b1;
               end
            end
            SEL_FLAG: begin
               clr_ev = hwdata[7:4];
            end
            SEL_ACC: begin
               next_s.acc_ctl = hwdata[7:0];
            end
            default: begin
               next_s.acc_ctl = s.acc_ctl;
            end
         endcase
      end

      // Prescaler and free-running counter
      if (tick) begin
         next_s.prescale = 4'h0;
         next_s.counter = s.counter + 16'h0001;
      end else begin
         next_s.prescale = s.prescale + 4'h1;
      end
      set_ev[`IDX_COUNTER_WRAP] = tick && (s.counter == 16'hFFFF);

      // Periodic divider chain never stops
      next_s.chain = s.chain + 16'h0001;
      set_ev[`IDX_PERIODIC] = timeout;

      set_ev[`IDX_ACC_OVERFLOW] = accumulator_wrap;
      set_ev[`IDX_ACC_EDGE] = accumulator_edge;

      // A set in the same cycle as a clear wins
      next_s.flags = (s.flags & ~clr_ev) | set_ev;

      next_s.irq = |(next_s.flags & next_s.en);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign irq = s.irq;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   counter_wrap_flag_a: assert property (
      (tick && s.counter == 16'hFFFF) |=> (s.counter == 16'h0000) && s.flags[`IDX_COUNTER_WRAP])
      else $error("wrap flag not set on counter rollover");

   counter_step_a: assert property (
      !tick |=> (s.counter == $past(s.counter)))
      else $error("counter moved without a prescaler tick");

   prescale_rate_a: assert property (
      (s.ratio == 2'h1 && tick) ##1 (s.ratio == 2'h1)[*4]
      |-> !$past(tick, 3) && !$past(tick, 2) && !$past(tick) && tick)
      else $error("divide by four spacing wrong");

   ratio_lock_a: assert property (
      (normal_mode && (s.ratio_locked || s.win_cnt == WINDOW_CYCLES)) |=> $stable(s.ratio))
      else $error("divider ratio changed after lock");

   chain_runs_a: assert property (
      $past(hresetn) |-> (s.chain == $past(s.chain) + 16'h0001))
      else $error("periodic chain stalled");

   periodic_cause_a: assert property (
      $rose(s.flags[`IDX_PERIODIC]) |-> $past(timeout))
      else $error("periodic flag rose without timeout");

   periodic_first_a: assert property (
      (s.chain == 16'h1FFE && s.acc_ctl[1:0] == 2'h0) |=> !s.flags[`IDX_PERIODIC] || $past(s.flags[`IDX_PERIODIC])
      ##1 s.flags[`IDX_PERIODIC])
      else $error("first periodic flag at wrong cycle");

   irq_follows_a: assert property (
      irq == |(s.flags & s.en))
      else $error("irq disagrees with flags and enables");

   flag_clear_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_FLAG && hwdata[6] && !timeout) |=> !s.flags[`IDX_PERIODIC])
      else $error("periodic flag not cleared by write of one");

   flag_hold_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_FLAG && !hwdata[7] && s.flags[`IDX_COUNTER_WRAP])
      |=> s.flags[`IDX_COUNTER_WRAP])
      else $error("zero write cleared the wrap flag");

   flag_read_zero_a: assert property (
      (addr_take && !hwrite && decode(haddr[7:0]) == SEL_FLAG) |=> (hrdata[3:0] == 4'h0))
      else $error("unimplemented flag bits read nonzero");

   mask_read_zero_a: assert property (
      (addr_take && !hwrite && decode(haddr[7:0]) == SEL_MASK) |=> (hrdata[3:2] == 2'h0))
      else $error("unimplemented mask bits read nonzero");

   acc_flags_set_a: assert property (
      (accumulator_wrap && accumulator_edge) |=> s.flags[`IDX_ACC_OVERFLOW] && s.flags[`IDX_ACC_EDGE])
      else $error("accumulator events did not set flags");

   acc_wrap_flag_a: assert property (
      accumulator_wrap |=> s.flags[`IDX_ACC_OVERFLOW])
      else $error("accumulator wrap did not set its flag");

   acc_edge_flag_a: assert property (
      accumulator_edge |=> s.flags[`IDX_ACC_EDGE])
      else $error("accumulator edge did not set its flag");

   wrap_irq_a: assert property (
      (s.flags[`IDX_COUNTER_WRAP] && s.en[`IDX_COUNTER_WRAP]) |-> irq)
      else $error("enabled wrap flag without irq");

   periodic_irq_a: assert property (
      (s.flags[`IDX_PERIODIC] && s.en[`IDX_PERIODIC]) |-> irq)
      else $error("enabled periodic flag without irq");

   mask_quiet_a: assert property (
      (s.en == 4'h0) |-> !irq)
      else $error("irq raised with every enable clear");

   clear_keeps_chain_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_FLAG) |=> (s.chain == $past(s.chain) + 16'h0001))
      else $error("flag write disturbed the periodic chain");

   timeout_sets_a: assert property (
      timeout |=> s.flags[`IDX_PERIODIC])
      else $error("timeout did not set periodic flag");

   timeout_tap_a: assert property (
      timeout |-> ((s.chain & `PERIODIC_BASE_MASK) == `PERIODIC_BASE_MASK))
      else $error("timeout off the base divider tap");

   wrap_cause_a: assert property (
      $rose(s.flags[`IDX_COUNTER_WRAP]) |-> ($past(s.counter) == 16'hFFFF) && (s.counter == 16'h0000))
      else $error("wrap flag rose without counter rollover");

   enable_write_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_MASK) |=> (s.en == $past(hwdata[7:4])))
      else $error("mask write did not load enables");

   ratio_write_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_MASK && ratio_open) |=> (s.ratio == $past(hwdata[1:0])))
      else $error("open ratio write not taken");

   window_hold_a: assert property (
      (s.win_cnt == WINDOW_CYCLES) |=> (s.win_cnt == WINDOW_CYCLES))
      else $error("write window reopened");

   rate_write_a: assert property (
      (s.wr_pend && decode(s.wr_addr) == SEL_ACC) |=> (s.acc_ctl == $past(hwdata[7:0])))
      else $error("control write not taken");

endmodule : periodic_timer

`default_nettype wire

// ==== verilog/timer_two_consts.svh ====
`ifndef TIMER_TWO_CONSTS_SVH
`define TIMER_TWO_CONSTS_SVH

// Byte offsets on the register bus
`define OFF_TIMER_MASK_TWO 8'h00
`define OFF_TIMER_FLAG_TWO 8'h04
`define OFF_ACC_CONTROL 8'h08
`define OFF_FREE_COUNTER 8'h0C

// Flag and enable nibble index (register bit = index + 4)
`define IDX_COUNTER_WRAP 3
`define IDX_PERIODIC 2
`define IDX_ACC_OVERFLOW 1
`define IDX_ACC_EDGE 0

// Field positions
`define POS_ENABLE_LSB 4
`define POS_FLAG_LSB 4
`define POS_RATIO_LSB 0
`define POS_RATE_LSB 0

// Reset values
`define RST_ENABLES 4'h0
`define RST_RATIO 2'h0
`define RST_FLAGS 4'h0
`define RST_ACC_CONTROL 8'h00
`define RST_COUNTER 16'h0000
`define RST_CHAIN 16'h0000

// Timing counts, in clock cycles
`define WRITE_WINDOW_CYCLES 7'h40
`define PERIODIC_BASE_MASK 16'h1FFF
`define PRESCALE_LAST_DIV1 4'h0
`define PRESCALE_LAST_DIV4 4'h3
`define PRESCALE_LAST_DIV8 4'h7
`define PRESCALE_LAST_DIV16 4'hF

`endif

// ==== verilog/timer_two_pkg.sv ====
`include "timer_two_consts.svh"

package timer_two_pkg;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_MASK = 3'h1,
      SEL_FLAG = 3'h3,
      SEL_ACC = 3'h2,
      SEL_COUNT = 3'h6
   } reg_sel_t;

   typedef struct packed {
      logic [3:0] en;
      logic [1:0] ratio;
      logic ratio_locked;
      logic [6:0] win_cnt;
      logic [3:0] flags;
      logic [7:0] acc_ctl;
      logic [3:0] prescale;
      logic [15:0] counter;
      logic [15:0] chain;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic irq;
   } state_t;

endpackage : timer_two_pkg
